// ### logic/fbcmd_gateway.sv
// Bit-command gateway: output image to framed serial commands, answers back
//
// Contract
// [RL1] Output byte 0 bit 0 set selects bit-command operation.
// [RL2] In bit-command operation, output data bytes are not sent as raw payload.
// [RL3] Answers still return in the selected mode, pass-through or buffered.
// [RL4] Each command bit sends its character framed by STX and CR LF.
// [RL5] Device answers go to the controller without any further request.
// [RL6] Byte 2 bit 1 opens and closes the reading gate.
// [RL7] Controller must not use bit commands with a hand-held scanner.
// [RL8] Only station addresses 0 to 63 are used for communication.
// [RL9] Station address is ones switch plus ten times tens switch.
// [RL10] Bit rate comes from the selector and must match the network.
// [RL11] Type selector and address switches are sampled at startup.
// [RL12] Pass-through transfer is the default mode after reset.
// [RL13] Buffered mode holds answers in a one-kilobyte buffer.
// [RL14] A command is sent once, on the rising edge of its bit; the gate bit also sends a command on its falling edge.
// [RL15] Simultaneous command bits are queued and sent one after another.
`timescale 1ns/1ns
module fbcmd_gateway
  import fbcmd_pkg::*;
(
  input wire logic clk_sys_i, // system clock, 10 MHz
  input wire logic resetn_i, // asynchronous reset, active low
  input wire logic [3:0] reg_addr_i, // register index
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [7:0] reg_rdata_o, // read data, cycle after read strobe
  input wire logic [3:0] address_ones_switch_i, // station address ones digit
  input wire logic [3:0] address_tens_switch_i, // station address tens digit
  input wire logic [3:0] bitrate_selector_i, // fieldbus bit rate selector
  input wire logic [3:0] end_device_type_selector_i, // connected device type
  output logic [3:0] bitrate_o, // bit rate handed to the fieldbus core
  output logic [3:0] dev_type_o, // latched device type for serial setup
  output logic addr_ok_o, // station address usable
  output logic [6:0] station_addr_o, // station address
  output logic [7:0] ser_tx_data_o, // serial transmit byte
  output logic ser_tx_valid_o, // serial transmit byte valid
  input wire logic ser_tx_ready_i, // serial transmitter takes the byte
  input wire logic [7:0] ser_rx_data_i, // serial receive byte
  input wire logic ser_rx_valid_i // serial receive byte strobe
);
  logic rst_meta_r;
  logic rst_n;
  logic [7:0] out_r [4];
  logic [7:0] cmd_prev_r;
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;
  logic [7:0] cur_char_r;
  fbcmd_state_t state_r;
  logic sampled_r;
  logic buf_mode_r;
  logic [7:0] rx_hold_r;
  logic rx_valid_r;
  logic [7:0] buf_mem [BUF_BYTES];
  logic [BUF_AW:0] buf_cnt_r;
  logic [BUF_AW-1:0] buf_wp_r;
  logic [BUF_AW-1:0] buf_rp_r;
  logic cmd_mode;
  logic [7:0] rise;
  logic [2:0] pick;
  logic pick_any;
  logic [7:0] pick_char;
  logic raw_go;
  logic [1:0] raw_idx_r;
  logic raw_busy_r;
  logic buf_rd;
  logic buf_wr;
  logic [6:0] addr_sum;
  fbcmd_byte_if tx_in ();
  fbcmd_byte_if tx_out ();

  // Reset release synchroniser
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Operands widened first so the tens product cannot wrap at four bits
  assign addr_sum = {3'b000, address_tens_switch_i} * 7'(TENS_WEIGHT)
    + {3'b000, address_ones_switch_i}; // RL9
  // Startup sampling of switches, once after reset release
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sampled_r <= 1'b0;
      station_addr_o <= 7'h00;
      addr_ok_o <= 1'b0;
      dev_type_o <= 4'h0;
      bitrate_o <= 4'h0;
    end else if (!sampled_r) begin
      sampled_r <= 1'b1;
      station_addr_o <= addr_sum; // RL9
      addr_ok_o <= (address_ones_switch_i <= DIGIT_MAX) && (address_tens_switch_i <= DIGIT_MAX)
        && (addr_sum <= ADDR_MAX); // RL8
      dev_type_o <= end_device_type_selector_i; // RL11
      bitrate_o <= bitrate_selector_i; // RL10
    end
  end

  // Controller output image and transfer mode
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) out_r[i] <= 8'h00;
      buf_mode_r <= 1'b0; // RL12
    end else if (reg_wr_i && addr_ok_o) begin // RL8
      if (reg_addr_i == REG_OUT0) out_r[0] <= reg_wdata_i;
      else if (reg_addr_i == REG_OUT1) out_r[1] <= reg_wdata_i;
      else if (reg_addr_i == REG_OUT2) out_r[2] <= reg_wdata_i;
      else if (reg_addr_i == REG_OUT3) out_r[3] <= reg_wdata_i;
      else if (reg_addr_i == REG_BUFMODE) buf_mode_r <= reg_wdata_i[0];
    end
  end

  assign cmd_mode = out_r[CTL0_BYTE][CMDMODE_BIT]; // RL1

  // Edge detection; the gate bit issues on both edges, the others on rising only
  assign rise = out_r[CMD_BYTE] & ~cmd_prev_r; // RL14
  always_comb begin
    pend_nxt = pend_r;
    // Clear only when the frame really starts, and before the set so a new edge wins
    if (state_r == FBCMD_IDLE && pick_any && cmd_mode && !raw_busy_r && tx_in.ready)
      pend_nxt[pick] = 1'b0;
    if (cmd_mode) pend_nxt = pend_nxt | rise; // RL15
    if (cmd_mode && (out_r[CMD_BYTE][GATE_BIT] != cmd_prev_r[GATE_BIT]))
      pend_nxt[GATE_BIT] = 1'b1; // RL6
  end

  // Lowest pending bit first keeps the queue order fixed
  always_comb begin
    pick = 3'd0;
    pick_any = 1'b0;
    for (int i = CMD_BITS - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        pick = 3'(i);
        pick_any = 1'b1;
      end
    end
  end

  // Gate bit maps to on or off; other bits carry their own ASCII command slot
  always_comb begin
    if (pick == 3'(GATE_BIT)) pick_char = out_r[CMD_BYTE][GATE_BIT] ? CH_GATE_ON : CH_GATE_OFF;
    else pick_char = out_r[CTL1_BYTE + 2] | {5'b00000, pick}; // RL4
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_prev_r <= 8'h00;
      pend_r <= 8'h00;
    end else begin
      cmd_prev_r <= out_r[CMD_BYTE];
      pend_r <= pend_nxt;
    end
  end

  // Frame sender: STX, char, CR one frame at a time; LF is added at the buffer output
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= FBCMD_IDLE;
      cur_char_r <= 8'h00;
    end else if (tx_in.ready) begin
      case (state_r)
        FBCMD_IDLE: begin
          if (pick_any && cmd_mode && !raw_busy_r) begin
            cur_char_r <= pick_char;
            state_r <= FBCMD_STX; // RL15
          end
        end
        FBCMD_STX: state_r <= FBCMD_CHAR;
        FBCMD_CHAR: state_r <= FBCMD_CR;
        FBCMD_CR: state_r <= FBCMD_IDLE;
        default: state_r <= FBCMD_IDLE;
      endcase
    end
  end

  // Raw payload path, used only outside bit-command operation
  assign raw_go = reg_wr_i && addr_ok_o && (reg_addr_i == REG_OUT3) && !cmd_mode; // RL2
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      raw_busy_r <= 1'b0;
      raw_idx_r <= 2'd0;
    end else if (raw_go && state_r == FBCMD_IDLE) begin
      raw_busy_r <= 1'b1;
      raw_idx_r <= 2'(CMD_BYTE);
    end else if (raw_busy_r && tx_in.ready) begin
      if (cmd_mode || raw_idx_r == 2'd3) raw_busy_r <= 1'b0; // RL2
      raw_idx_r <= raw_idx_r + 2'd1;
    end
  end

  always_comb begin
    tx_in.valid = 1'b0;
    tx_in.data = CH_NUL;
    case (state_r)
      FBCMD_STX: begin
        tx_in.valid = 1'b1;
        tx_in.data = CH_STX; // RL4
      end
      FBCMD_CHAR: begin
        tx_in.valid = 1'b1;
        tx_in.data = cur_char_r;
      end
      FBCMD_CR: begin
        tx_in.valid = 1'b1;
        tx_in.data = CH_CR;
      end
      default: begin
        if (raw_busy_r && !cmd_mode && out_r[raw_idx_r] != CH_NUL) begin
          tx_in.valid = 1'b1;
          tx_in.data = out_r[raw_idx_r];
        end
      end
    endcase
  end

  fbcmd_skid u_skid (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .up(tx_in),
    .dn(tx_out)
  );

  // LF trails CR: inserted at the buffer output so the frame stays contiguous
  logic lf_due_r;
  assign tx_out.ready = !lf_due_r && (!ser_tx_valid_o || ser_tx_ready_i);
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_tx_valid_o <= 1'b0;
      ser_tx_data_o <= 8'h00;
      lf_due_r <= 1'b0;
    end else if (!ser_tx_valid_o || ser_tx_ready_i) begin
      if (lf_due_r) begin
        ser_tx_valid_o <= 1'b1;
        ser_tx_data_o <= CH_LF; // RL4
        lf_due_r <= 1'b0;
      end else begin
        ser_tx_valid_o <= tx_out.valid;
        ser_tx_data_o <= tx_out.data;
        lf_due_r <= tx_out.valid && tx_out.data == CH_CR && !raw_busy_r;
      end
    end
  end

  // Answer path: pass-through hold register or 1 KiB buffer
  assign buf_wr = ser_rx_valid_i && buf_mode_r && buf_cnt_r != (BUF_AW+1)'(BUF_BYTES); // RL13
  assign buf_rd = reg_rd_i && reg_addr_i == REG_RXDATA && buf_mode_r && buf_cnt_r != '0;
  always_ff @(posedge clk_sys_i) begin
    if (buf_wr) buf_mem[buf_wp_r] <= ser_rx_data_i;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      buf_wp_r <= '0;
      buf_rp_r <= '0;
      buf_cnt_r <= '0;
    end else begin
      if (buf_wr) buf_wp_r <= buf_wp_r + 1'b1;
      if (buf_rd) buf_rp_r <= buf_rp_r + 1'b1;
      buf_cnt_r <= buf_cnt_r + (BUF_AW+1)'(buf_wr) - (BUF_AW+1)'(buf_rd);
    end
  end

  // Pass-through: newest answer byte presented at once; a new byte wins over the read clear
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_hold_r <= 8'h00;
      rx_valid_r <= 1'b0;
    end else if (ser_rx_valid_i && !buf_mode_r) begin
      rx_hold_r <= ser_rx_data_i; // RL5
      rx_valid_r <= 1'b1; // RL3
    end else if (reg_rd_i && reg_addr_i == REG_RXDATA) begin
      rx_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= RD_ZERO;
    end else if (reg_rd_i) begin
      if (reg_addr_i == REG_OUT0) reg_rdata_o <= out_r[0];
      else if (reg_addr_i == REG_OUT1) reg_rdata_o <= out_r[1];
      else if (reg_addr_i == REG_OUT2) reg_rdata_o <= out_r[2];
      else if (reg_addr_i == REG_OUT3) reg_rdata_o <= out_r[3];
      else if (reg_addr_i == REG_RXDATA) reg_rdata_o <= buf_mode_r ? buf_mem[buf_rp_r] : rx_hold_r;
      else if (reg_addr_i == REG_STATUS) begin
        reg_rdata_o <= RD_ZERO;
        reg_rdata_o[ST_RXVALID] <= rx_valid_r;
        reg_rdata_o[ST_BUFDATA] <= buf_cnt_r != '0;
        reg_rdata_o[ST_ADDROK] <= addr_ok_o;
        reg_rdata_o[ST_CMDMODE] <= cmd_mode;
        reg_rdata_o[ST_BUSY] <= state_r != FBCMD_IDLE;
      end
      else if (reg_addr_i == REG_SETUP) reg_rdata_o <= {dev_type_o, bitrate_o};
      else if (reg_addr_i == REG_BUFMODE) reg_rdata_o <= {7'h00, buf_mode_r};
      else reg_rdata_o <= RD_ZERO;
    end else begin
      reg_rdata_o <= RD_ZERO;
    end
  end

  a_stx_then_char: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RL4
    (state_r == FBCMD_STX && tx_in.ready) |=> state_r == FBCMD_CHAR)
    else $error("command frame skipped its character");
  a_no_raw_cmdmode: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RL2
    (cmd_mode && state_r == FBCMD_IDLE) |-> !tx_in.valid)
    else $error("raw payload sent in bit-command operation");
  a_rise_queued: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RL15
    (cmd_mode && rise[0]) |=> pend_r[0])
    else $error("rising command bit lost");
  a_gate_char: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RL6
    (state_r == FBCMD_IDLE && tx_in.ready && cmd_mode && !raw_busy_r && pick_any
     && pick == 3'(GATE_BIT) && out_r[CMD_BYTE][GATE_BIT]) |=> cur_char_r == CH_GATE_ON)
    else $error("gate-on character wrong");
  a_rx_pass: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RL5
    (ser_rx_valid_i && !buf_mode_r) |=> rx_valid_r && rx_hold_r == $past(ser_rx_data_i))
    else $error("answer byte not forwarded");
  a_addr_range: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RL8
    addr_ok_o |-> station_addr_o <= ADDR_MAX)
    else $error("station address out of range accepted");
  a_buf_store: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RL13
    (buf_wr && !buf_rd) |=> buf_cnt_r == $past(buf_cnt_r) + 1'b1)
    else $error("buffered answer not counted");
  a_default_pass: assert property (@(posedge clk_sys_i) // RL12
    $rose(rst_n) |-> !buf_mode_r)
    else $error("buffered mode after reset");
endmodule

// ### logic/fbcmd_pkg.sv
// Package of constants and types for the fieldbus bit-command block
package fbcmd_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // Output image layout
  localparam int unsigned CTL0_BYTE = 0;
  localparam int unsigned CMDMODE_BIT = 0;
  localparam int unsigned CTL1_BYTE = 1;
  localparam int unsigned CMD_BYTE = 2;
  localparam int unsigned GATE_BIT = 1;
  localparam int unsigned CMD_BITS = 8;
  // Serial framing characters
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_GATE_ON = 8'h2b;
  localparam logic [7:0] CH_GATE_OFF = 8'h2d;
  localparam logic [7:0] CH_NUL = 8'h00;
  // Station address limits
  localparam logic [6:0] ADDR_MAX = 7'h3f;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] TENS_WEIGHT = 4'ha;
  // Buffered answer store
  localparam int unsigned BUF_BYTES = 1024;
  localparam int unsigned BUF_AW = 10;
  // Register map over the plain port
  localparam logic [3:0] REG_OUT0 = 4'h0;
  localparam logic [3:0] REG_OUT1 = 4'h1;
  localparam logic [3:0] REG_OUT2 = 4'h2;
  localparam logic [3:0] REG_OUT3 = 4'h3;
  localparam logic [3:0] REG_RXDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_SETUP = 4'h6;
  localparam logic [3:0] REG_BUFMODE = 4'h7;
  localparam int unsigned ST_RXVALID = 0;
  localparam int unsigned ST_BUFDATA = 1;
  localparam int unsigned ST_ADDROK = 2;
  localparam int unsigned ST_CMDMODE = 3;
  localparam int unsigned ST_BUSY = 4;
  localparam logic [7:0] RD_ZERO = 8'h00;
  typedef enum logic [1:0] {FBCMD_IDLE, FBCMD_STX, FBCMD_CHAR, FBCMD_CR} fbcmd_state_t;
endpackage

// ### logic/fbcmd_byte_if.sv
// Valid/ready byte stream between the gateway and its skid buffer
`timescale 1ns/1ns
interface fbcmd_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### logic/fbcmd_skid.sv
// Two-entry valid/ready buffer for the serial transmit byte stream
`timescale 1ns/1ns
module fbcmd_skid
  import fbcmd_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronous-released reset
  fbcmd_byte_if.snk up, // filling side
  fbcmd_byte_if.src dn // draining side
);
  logic [7:0] mem_r [2];
  logic rd_ptr_r;
  logic wr_ptr_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign up.ready = (cnt_r != 2'd2);
  assign dn.valid = (cnt_r != 2'd0);
  assign dn.data = mem_r[rd_ptr_r];
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_r[wr_ptr_r] <= up.data;
  end

  a_skid_no_overfill: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_r != 2'd3)
    else $error("skid buffer count past its depth");
endmodule

// ### verification/fbcmd_serial_dev.sv
// Model of the serial identification device on the gateway's transmit and receive bytes
`timescale 1ns/1ns
module fbcmd_serial_dev (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // reset, active low
  input wire logic stall_i, // hold off one cycle in four
  input wire logic [7:0] tx_data_i, // byte from the gateway
  input wire logic tx_valid_i, // byte offered
  output logic tx_ready_o, // byte taken at this edge
  output logic [7:0] rx_data_o, // answer byte
  output logic rx_valid_o // answer strobe, one cycle
);
  logic [7:0] log [0:63];
  int n;
  logic [1:0] cnt_r;
  logic [7:0] last_r;
  logic ans_r;
  // Takes bytes only on a handshake edge and logs them for the bench
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      n <= 0;
      cnt_r <= 2'h0;
      tx_ready_o <= 1'b0;
      ans_r <= 1'b0;
      last_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      tx_ready_o <= stall_i ? (cnt_r != 2'h0) : 1'b1;
      ans_r <= 1'b0;
      if (tx_valid_i && tx_ready_o) begin
        log[n[5:0]] <= tx_data_i;
        n <= n + 1;
        if (tx_data_i == 8'h0a) begin
          ans_r <= 1'b1;
        end else if (tx_data_i != 8'h0d) begin
          last_r <= tx_data_i;
        end
      end
    end
  end
  // Answers every framed command once; the line toggles when no answer stands
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
    end else begin
      rx_valid_o <= ans_r;
      rx_data_o <= ans_r ? last_r + 8'h01 : ~rx_data_o;
    end
  end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the bit-command gateway
`timescale 1ns/1ns
module testbench;
  import fbcmd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [3:0] ones = 4'h3;
  logic [3:0] tens = 4'h4;
  logic [3:0] rate = 4'h2;
  logic [3:0] dtype = 4'h1;
  logic [3:0] bitrate_o, dev_type_o;
  logic addr_ok_o, ser_tx_valid_o, ser_tx_ready_i, ser_rx_valid_i, stall;
  logic [6:0] station_addr_o;
  logic [7:0] ser_tx_data_o, ser_rx_data_i, v;
  int miscompares = 0;
  int checks_done = 0;
  int n0;
  logic [7:0] wv [0:5] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h80, 8'h00};
  logic [7:0] cv [0:5] = '{8'h40, 8'h00, 8'h2b, 8'h2d, 8'h47, 8'h00};
  always #50 clk_sys_i = ~clk_sys_i;
  fbcmd_gateway u_fbcmd_gateway (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .address_ones_switch_i(ones),
    .address_tens_switch_i(tens), .bitrate_selector_i(rate),
    .end_device_type_selector_i(dtype), .bitrate_o(bitrate_o), .dev_type_o(dev_type_o),
    .addr_ok_o(addr_ok_o), .station_addr_o(station_addr_o), .ser_tx_data_o(ser_tx_data_o),
    .ser_tx_valid_o(ser_tx_valid_o), .ser_tx_ready_i(ser_tx_ready_i),
    .ser_rx_data_i(ser_rx_data_i), .ser_rx_valid_i(ser_rx_valid_i));
  fbcmd_serial_dev u_fbcmd_serial_dev (.clk_i(clk_sys_i), .rst_n_i(resetn_i),
    .stall_i(stall), .tx_data_i(ser_tx_data_o), .tx_valid_i(ser_tx_valid_o),
    .tx_ready_o(ser_tx_ready_i), .rx_data_o(ser_rx_data_i), .rx_valid_o(ser_rx_valid_i));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Bounded wait until the device has logged k bytes, then lets any answer land
  task automatic wait_n(input int k);
    for (int i = 0; i < 300 && u_fbcmd_serial_dev.n < k; i++) @(posedge clk_sys_i);
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("byte count", k[7:0], u_fbcmd_serial_dev.n[7:0]);
  endtask
  task automatic frame(input int s, input logic [7:0] c);
    chk("stx", CH_STX, u_fbcmd_serial_dev.log[s]);
    chk("char", c, u_fbcmd_serial_dev.log[s + 1]);
    chk("cr", CH_CR, u_fbcmd_serial_dev.log[s + 2]);
    chk("lf", CH_LF, u_fbcmd_serial_dev.log[s + 3]);
  endtask
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk("tx valid in reset", 8'h00, {7'h0, ser_tx_valid_o});
    chk("addr ok in reset", 8'h00, {7'h0, addr_ok_o});
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    miscompares++;
    test_done();
  end
  initial begin
    stall = 1'b0;
    do_reset();
    chk("station", 8'd43, {1'b0, station_addr_o});
    chk("addr ok", 8'h01, {7'h0, addr_ok_o});
    chk("bitrate", {4'h0, rate}, {4'h0, bitrate_o});
    chk("dev type", {4'h0, dtype}, {4'h0, dev_type_o});
    rd(REG_SETUP, v);
    chk("setup", 8'h12, v);
    rd(REG_BUFMODE, v);
    chk("buf mode", 8'h00, v);
    wr(REG_OUT3, 8'h40);
    wr(REG_OUT0, 8'h01);
    rd(REG_STATUS, v);
    chk("cmd mode", 8'h08, v & 8'h08);
    chk("addr ok bit", 8'h04, v & 8'h04);
    $display("startup test done");
    foreach (wv[i]) begin
      n0 = u_fbcmd_serial_dev.n;
      wr(REG_OUT2, wv[i]);
      wait_n(n0 + (cv[i] != 8'h00 ? 4 : 0));
      if (cv[i] != 8'h00) begin
        frame(n0, cv[i]);
        rd(REG_STATUS, v);
        chk("rx valid", 8'h01, v & 8'h01);
        rd(REG_RXDATA, v);
        chk("answer", cv[i] + 8'h01, v);
      end
    end
    $display("row test done");
    stall = 1'b1;
    n0 = u_fbcmd_serial_dev.n;
    wr(REG_OUT2, 8'h0c);
    wait_n(n0 + 8);
    frame(n0, 8'h42);
    frame(n0 + 4, 8'h43);
    rd(REG_RXDATA, v);
    chk("last answer", 8'h44, v);
    wr(REG_OUT2, 8'h0c);
    wait_n(n0 + 8);
    $display("queue test done");
    wr(REG_BUFMODE, 8'h01);
    wr(REG_OUT2, 8'h00);
    wr(REG_OUT2, 8'h30);
    wait_n(n0 + 16);
    frame(n0 + 8, 8'h44);
    frame(n0 + 12, 8'h45);
    rd(REG_STATUS, v);
    chk("buf data", 8'h02, v & 8'h02);
    rd(REG_RXDATA, v);
    chk("buf first", 8'h45, v);
    rd(REG_RXDATA, v);
    chk("buf second", 8'h46, v);
    rd(REG_STATUS, v);
    chk("buf empty", 8'h00, v & 8'h02);
    $display("buffer test done");
    n0 = u_fbcmd_serial_dev.n;
    wr(REG_OUT3, 8'h55);
    wait_n(n0);
    wr(REG_OUT0, 8'h00);
    rd(REG_STATUS, v);
    chk("cmd off", 8'h00, v & 8'h08);
    wr(REG_OUT3, 8'h66);
    wait_n(n0 + 2);
    chk("raw 2", 8'h30, u_fbcmd_serial_dev.log[n0]);
    chk("raw 3", 8'h66, u_fbcmd_serial_dev.log[n0 + 1]);
    $display("payload test done");
    ones <= 4'h8;
    repeat (3) @(posedge clk_sys_i);
    chk("switch held", 8'd43, {1'b0, station_addr_o});
    ones <= 4'h4;
    tens <= 4'h6;
    do_reset();
    chk("station 64", 8'd64, {1'b0, station_addr_o});
    chk("addr bad", 8'h00, {7'h0, addr_ok_o});
    wr(REG_OUT0, 8'h01);
    rd(REG_OUT0, v);
    chk("write refused", 8'h00, v);
    rd(4'h8, v);
    chk("unmapped", RD_ZERO, v);
    $display("address test done");
    test_done();
  end
endmodule
